//--- dcdi_map.vh
/*
 Constants for the data channel interface: host device codes, field
 positions, select codes and reset values.
 Assumes inclusion by dcdi_top.v only; holds definitions and nothing else.
*/
// Behaviour
// R01 - Start sets busy, clears done, begins transfer
// R02 - Clear drops flags, keeps transfer in flight
// R03 - Aux pulse clears only window-closed flag
// R04 - Global reset also cancels channel activity
// R05 - Port A write loads buffer address
// R06 - Port B write loads negated word count
// R07 - Port C write loads four-bit select code
// R08 - Select code drives one of five lines
// R09 - Port A read returns next buffer address
// R10 - Port B read strobes status, code low
// R11 - Busy line to devices; devices request words
// R12 - Address request gates address, increments counters
// R13 - Direction from select bit; strobes forwarded
// R14 - Burst request holds channel back to back
// R15 - Count reaching zero sets done, interrupts
// R16 - Window closed sets second, unskippable done
// R17 - Status carries modulation allowed and ready
// R18 - Input port returns three-bit sensitivity field
// R19 - Input port returns radar threshold bits
// R20 - Input port returns Gray altitude, no top
// R21 - Codes six and seven; mask bit eight
// R22 - Mask-out loads disable; one inhibits interrupts
// R23 - Request while any done and enabled
`ifndef DCDI_MAP_VH
`define DCDI_MAP_VH

`define DCDI_CODE_PIO 6'h06
`define DCDI_CODE_DCH 6'h07
// Mask bit 8 counted from the MSB
`define DCDI_MASK_BIT 7

`define DCDI_SEL_MOD 4'h0
`define DCDI_SEL_REPLY1 4'h1
`define DCDI_SEL_REPLY2 4'h3
`define DCDI_SEL_XPDR_OUT 4'h2
`define DCDI_SEL_XPDR_IN 4'h5

`define DCDI_LINE_MOD 0
`define DCDI_LINE_REPLY1 1
`define DCDI_LINE_REPLY2 2
`define DCDI_LINE_XPDR_OUT 3
`define DCDI_LINE_XPDR_IN 4

`define DCDI_STAT_ME_BIT 15
`define DCDI_STAT_MR_BIT 14

`define DCDI_RST_WORD 16'h0000
`define DCDI_RST_SEL 4'h0
`define DCDI_RST_LINES 5'h00

`endif

//--- dcdi_top.v
/*
 Data channel interface between the host I/O bus and five channel
 devices, plus the programmed input port for altimeter and switch data.
 Assumes bus pulses last one clock, are synchronous to i_clock and, except
 for global reset and mask-out, are qualified by i_dev_code; read answers appear on the data lines for one
 cycle with an output enable.
*/
`timescale 1ns/1ps
`include "dcdi_map.vh"

module dcdi_top
(
	input wire i_clock,
	input wire i_reset_n,
	input wire [5:0] i_dev_code,
	input wire [15:0] i_bus_data,
	input wire i_write_port_a,
	input wire i_write_port_b,
	input wire i_write_port_c,
	input wire i_read_port_a,
	input wire i_read_port_b,
	input wire i_start_pulse,
	input wire i_clear_pulse,
	input wire i_no_transfer_aux_pulse,
	input wire i_global_io_reset,
	input wire i_mask_out,
	input wire i_dch_addr_req,
	input wire i_dch_in_strobe,
	input wire i_dch_out_strobe,
	input wire i_device_word_req,
	input wire i_burst_request,
	input wire i_window_closed,
	input wire i_modulation_allowed,
	input wire i_modulator_ready,
	input wire [11:0] i_device_status,
	input wire [2:0] i_sensitivity_setting,
	input wire [2:0] i_radar_threshold_bits,
	input wire [9:0] i_altitude_code,
	output reg [15:0] o_bus_data,
	output reg o_bus_data_oe,
	output reg o_dch_request,
	output reg o_dch_dir_in,
	output reg o_dch_burst,
	output reg o_busy,
	output reg o_done,
	output reg o_window_done,
	output reg o_irq,
	output reg [4:0] o_select_lines,
	output reg o_status_strobe,
	output reg o_channel_input_strobe,
	output reg o_channel_output_strobe
);

// ----------------------------------------
// States
// ----------------------------------------
localparam ST_IDLE = 2'b00;
localparam ST_REQ = 2'b01;
localparam ST_XFER = 2'b10;

// ----------------------------------------
// Decode
// ----------------------------------------
wire pio_hit;
wire dch_hit;
wire wr_a;
wire wr_b;
wire wr_c;
wire rd_a;
wire rd_b;
wire start_hit;
wire clear_hit;
wire aux_hit;
wire pio_rd;
wire exhaust;
wire [15:0] count_inc;

assign pio_hit = (i_dev_code == `DCDI_CODE_PIO); // see R21
assign dch_hit = (i_dev_code == `DCDI_CODE_DCH); // see R21
assign wr_a = i_write_port_a & dch_hit;
assign wr_b = i_write_port_b & dch_hit;
assign wr_c = i_write_port_c & dch_hit;
assign rd_a = i_read_port_a & dch_hit;
assign rd_b = i_read_port_b & dch_hit;
assign pio_rd = i_read_port_a & pio_hit;
// Control pulses to the programmed port have no effect by design
assign start_hit = i_start_pulse & dch_hit;
assign clear_hit = i_clear_pulse & dch_hit;
assign aux_hit = i_no_transfer_aux_pulse & dch_hit;

// ----------------------------------------
// Registers
// ----------------------------------------
reg [15:0] addr_reg;
reg [15:0] addr_next;
reg [15:0] count_reg;
reg [15:0] count_next;
reg [3:0] sel_reg;
reg [1:0] state_reg;
reg [1:0] state_next;
reg busy_next;
reg done_next;
reg wdone_next;
reg disable_reg;
reg disable_next;
reg status_pend_reg;

assign count_inc = count_reg + 16'h0001;
assign exhaust = (state_reg == ST_REQ) & i_dch_addr_req & (count_inc == 16'h0000);

always @*
begin
	addr_next = addr_reg;
	count_next = count_reg;
	state_next = state_reg;
	busy_next = o_busy;
	done_next = o_done;
	wdone_next = o_window_done;
	disable_next = disable_reg;
	if (wr_a)
	begin
		addr_next = i_bus_data; // see R05
	end
	if (wr_b)
	begin
		count_next = i_bus_data; // see R06
	end
	if (i_mask_out)
	begin
		disable_next = i_bus_data[`DCDI_MASK_BIT]; // see R22
	end
	if (start_hit)
	begin
		busy_next = 1'b1; // see R01
		done_next = 1'b0; // see R01
	end
	if (clear_hit)
	begin
		busy_next = 1'b0; // see R02
		done_next = 1'b0; // see R02
		wdone_next = 1'b0; // see R02
	end
	if (aux_hit)
	begin
		wdone_next = 1'b0; // see R03
	end
	case (state_reg)
		ST_IDLE:
		begin
			// Only a busy channel accepts new word requests
			if (o_busy & i_device_word_req)
			begin
				state_next = ST_REQ; // see R11
			end
		end
		ST_REQ:
		begin
			if (i_dch_addr_req)
			begin
				addr_next = addr_reg + 16'h0001; // see R12
				count_next = count_inc; // see R12
				state_next = ST_XFER;
			end
		end
		ST_XFER:
		begin
			if (i_dch_in_strobe | i_dch_out_strobe)
			begin
				// Burst keeps the channel while count remains
				if (i_burst_request & o_busy & (count_reg != 16'h0000))
				begin
					state_next = ST_REQ; // see R14
				end
				else
				begin
					state_next = ST_IDLE;
				end
			end
		end
		default:
		begin
			state_next = ST_IDLE;
		end
	endcase
	// Event wins over a clear in the same cycle
	if (exhaust)
	begin
		busy_next = 1'b0; // see R15
		done_next = 1'b1; // see R15
	end
	if (i_window_closed)
	begin
		wdone_next = 1'b1; // see R16
	end
	if (i_global_io_reset)
	begin
		busy_next = 1'b0; // see R04
		done_next = 1'b0; // see R04
		wdone_next = 1'b0; // see R04
		disable_next = 1'b0; // see R04
		state_next = ST_IDLE; // see R04
	end
end

always @(posedge i_clock or negedge i_reset_n)
begin
	if (!i_reset_n)
	begin
		addr_reg <= `DCDI_RST_WORD;
		count_reg <= `DCDI_RST_WORD;
		sel_reg <= `DCDI_RST_SEL;
		state_reg <= ST_IDLE;
		o_busy <= 1'b0;
		o_done <= 1'b0;
		o_window_done <= 1'b0;
		disable_reg <= 1'b0;
		o_irq <= 1'b0;
		status_pend_reg <= 1'b0;
	end
	else
	begin
		addr_reg <= addr_next;
		count_reg <= count_next;
		state_reg <= state_next;
		o_busy <= busy_next;
		o_done <= done_next;
		o_window_done <= wdone_next;
		disable_reg <= disable_next;
		// Recomputed every cycle so clearing disable fires at once
		o_irq <= (done_next | wdone_next) & ~disable_next; // see R23
		status_pend_reg <= rd_b;
		if (wr_c)
		begin
			sel_reg <= i_bus_data[3:0]; // see R07
		end
	end
end

// ----------------------------------------
// Device side
// ----------------------------------------
always @(posedge i_clock or negedge i_reset_n)
begin
	if (!i_reset_n)
	begin
		o_select_lines <= `DCDI_RST_LINES;
		o_dch_request <= 1'b0;
		o_dch_dir_in <= 1'b0;
		o_dch_burst <= 1'b0;
		o_status_strobe <= 1'b0;
		o_channel_input_strobe <= 1'b0;
		o_channel_output_strobe <= 1'b0;
	end
	else
	begin
		o_select_lines <= `DCDI_RST_LINES;
		case (sel_reg)
			`DCDI_SEL_MOD: o_select_lines[`DCDI_LINE_MOD] <= 1'b1; // see R08
			`DCDI_SEL_REPLY1: o_select_lines[`DCDI_LINE_REPLY1] <= 1'b1; // see R08
			`DCDI_SEL_REPLY2: o_select_lines[`DCDI_LINE_REPLY2] <= 1'b1; // see R08
			`DCDI_SEL_XPDR_OUT: o_select_lines[`DCDI_LINE_XPDR_OUT] <= 1'b1; // see R08
			`DCDI_SEL_XPDR_IN: o_select_lines[`DCDI_LINE_XPDR_IN] <= 1'b1; // see R08
			default: o_select_lines <= `DCDI_RST_LINES;
		endcase
		o_dch_request <= (state_next == ST_REQ);
		o_dch_dir_in <= sel_reg[0]; // see R13
		o_dch_burst <= i_burst_request & (state_next != ST_IDLE); // see R14
		o_status_strobe <= rd_b; // see R10
		// Strobes pass only during our own transfer
		o_channel_input_strobe <= i_dch_in_strobe & (state_reg == ST_XFER); // see R13
		o_channel_output_strobe <= i_dch_out_strobe & (state_reg == ST_XFER); // see R13
	end
end

// ----------------------------------------
// Bus answers
// ----------------------------------------
reg [15:0] status_word;

always @*
begin
	status_word = {i_device_status, sel_reg}; // see R10
	status_word[`DCDI_STAT_ME_BIT] = i_device_status[11] | i_modulation_allowed; // see R17
	status_word[`DCDI_STAT_MR_BIT] = i_device_status[10] | i_modulator_ready; // see R17
end

always @(posedge i_clock or negedge i_reset_n)
begin
	if (!i_reset_n)
	begin
		o_bus_data <= `DCDI_RST_WORD;
		o_bus_data_oe <= 1'b0;
	end
	else
	begin
		o_bus_data <= `DCDI_RST_WORD;
		o_bus_data_oe <= 1'b0;
		if ((state_reg == ST_REQ) & i_dch_addr_req)
		begin
			o_bus_data <= addr_reg; // see R12
			o_bus_data_oe <= 1'b1;
		end
		else if (rd_a)
		begin
			o_bus_data <= addr_reg; // see R09
			o_bus_data_oe <= 1'b1;
		end
		else if (status_pend_reg)
		begin
			// Device status sampled one cycle after the strobe
			o_bus_data <= status_word; // see R10
			o_bus_data_oe <= 1'b1;
		end
		else if (pio_rd)
		begin
			o_bus_data <= {i_radar_threshold_bits[0], i_radar_threshold_bits[1],
				i_sensitivity_setting, i_radar_threshold_bits[2],
				i_altitude_code}; // see R18 see R19 see R20
			o_bus_data_oe <= 1'b1;
		end
	end
end

endmodule // dcdi_top

//--- dcdi_chk.sv
/*
 Port checker for dcdi_top, bound below.
 Assumes one clock and the async active-low reset.
*/
`timescale 1ns/1ps
module dcdi_chk
(
	input wire i_clock,
	input wire i_reset_n,
	input wire [5:0] i_dev_code,
	input wire i_start_pulse,
	input wire i_clear_pulse,
	input wire i_no_transfer_aux_pulse,
	input wire i_global_io_reset,
	input wire i_read_port_b,
	input wire i_dch_addr_req,
	input wire i_dch_in_strobe,
	input wire i_dch_out_strobe,
	input wire i_window_closed,
	input wire o_bus_data_oe,
	input wire o_dch_request,
	input wire o_busy,
	input wire o_done,
	input wire o_window_done,
	input wire o_irq,
	input wire [4:0] o_select_lines,
	input wire o_status_strobe,
	input wire o_channel_input_strobe,
	input wire o_channel_output_strobe
);
// ----
// Properties
// ----
default clocking @(posedge i_clock); endclocking
default disable iff (!i_reset_n);
wire dch = i_dev_code == 6'h07;
// Flag sets win over clears, so keep them out
wire calm = !i_dch_addr_req && !i_window_closed && !i_global_io_reset;
sequence s_gate;
	o_dch_request && i_dch_addr_req;
endsequence
a_start_busy: assert property (dch && i_start_pulse && !i_clear_pulse && calm
	|=> o_busy && !o_done) else $error("start did not set busy");
a_clear_flags: assert property (dch && i_clear_pulse && !i_start_pulse && calm
	|=> !o_busy && !o_done && !o_window_done) else $error("clear left a flag");
a_aux_window: assert property (dch && i_no_transfer_aux_pulse && !i_start_pulse
	&& !i_clear_pulse && calm |=> !o_window_done && $stable(o_busy) && $stable(o_done))
	else $error("aux pulse wrong");
a_global_cancel: assert property (i_global_io_reset && !i_dch_addr_req
	|=> !o_busy && !o_done && !o_dch_request) else $error("global reset incomplete");
a_select_onehot: assert property ($onehot0(o_select_lines))
	else $error("select lines not one-hot");
a_req_busy: assert property ($rose(o_dch_request) |-> $past(o_busy))
	else $error("request without busy");
a_addr_gate: assert property (s_gate |=> o_bus_data_oe && !o_dch_request)
	else $error("address not gated");
a_strobe_fwd: assert property (s_gate ##2 (i_dch_in_strobe || i_dch_out_strobe)
	|=> o_channel_input_strobe == $past(i_dch_in_strobe)
	&& o_channel_output_strobe == $past(i_dch_out_strobe)) else $error("strobe lost");
a_status_walk: assert property (dch && i_read_port_b && !o_dch_request
	&& !i_dch_addr_req |=> o_status_strobe ##1 o_bus_data_oe) else $error("status walk");
a_irq_idle: assert property (!o_done && !o_window_done |-> !o_irq)
	else $error("irq without done");
a_done_idle: assert property ($rose(o_done) |-> !o_busy)
	else $error("done with busy");
endmodule // dcdi_chk

bind dcdi_top dcdi_chk u_chk(.i_clock, .i_reset_n, .i_dev_code, .i_start_pulse,
	.i_clear_pulse, .i_no_transfer_aux_pulse, .i_global_io_reset, .i_read_port_b,
	.i_dch_addr_req, .i_dch_in_strobe, .i_dch_out_strobe, .i_window_closed,
	.o_bus_data_oe, .o_dch_request, .o_busy, .o_done, .o_window_done, .o_irq,
	.o_select_lines, .o_status_strobe, .o_channel_input_strobe, .o_channel_output_strobe);

//--- dcdi_host_model.sv
/*
 Host data channel side: answers requests with an address request and a strobe.
 Assumes requests are registered on the rising edge.
*/
`timescale 1ns/1ps
module dcdi_host_model
(
	input wire i_clock,
	input wire i_reset_n,
	input wire i_stall,
	input wire i_request,
	input wire i_dir_in,
	output reg o_addr_req,
	output reg o_in_strobe,
	output reg o_out_strobe
);
reg gated_reg;
reg stall_reg;
// Stall taken on the rising edge, clear of the bench's falling-edge drive
always @(posedge i_clock or negedge i_reset_n)
begin
	if (!i_reset_n)
		stall_reg <= 1'b0;
	else
		stall_reg <= i_stall;
end
// Falling edge drive keeps setup clear of the sampling edge
always @(negedge i_clock or negedge i_reset_n)
begin
	if (!i_reset_n)
	begin
		o_addr_req <= 1'b0;
		gated_reg <= 1'b0;
		o_in_strobe <= 1'b0;
		o_out_strobe <= 1'b0;
	end
	else
	begin
		o_addr_req <= i_request && !o_addr_req && !stall_reg;
		gated_reg <= o_addr_req;
		o_in_strobe <= gated_reg && i_dir_in;
		o_out_strobe <= gated_reg && !i_dir_in;
	end
end
endmodule // dcdi_host_model

//--- data_channel_dma_interface_tb_top.sv
/*
 Self-checking bench for dcdi_top with the host model.
 Assumes bus pulses of one cycle, driven on the falling edge.
*/
`timescale 1ns/1ps
module data_channel_dma_interface_tb_top;
localparam [23:0] CS = 24'h013254;
localparam [29:0] LS = {5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00};
reg clk = 0;
reg rst_n = 0;
reg [9:0] cmd = 0;
reg [5:0] code = 0;
reg [15:0] bus = 0;
reg [11:0] dst = 0;
reg wreq = 0, burst = 0, win = 0, me = 0, mr = 0, stall = 0;
reg [2:0] sens = 3'h4, thr = 3'h6;
reg [9:0] alt = 10'h2A5;
integer n_fail = 0, checks = 0, n_io = 0;
wire [15:0] dout;
wire [4:0] sel;
wire oe, req, dir, busy, done, wdone, irq, ist, ost, areq, hin, hout, bst;
wire [15:0] flg = {11'h000, busy, done, wdone, irq, req};
always #2.5 clk = ~clk;
// Strobes are unknown until the first reset edge, so count only out of reset
always @(posedge clk) if (rst_n) n_io <= n_io + ist + ost;
dcdi_top uut(.i_clock(clk), .i_reset_n(rst_n), .i_dev_code(code), .i_bus_data(bus),
	.i_write_port_a(cmd[0]), .i_write_port_b(cmd[1]), .i_write_port_c(cmd[2]),
	.i_read_port_a(cmd[3]), .i_read_port_b(cmd[4]), .i_start_pulse(cmd[5]),
	.i_clear_pulse(cmd[6]), .i_no_transfer_aux_pulse(cmd[7]), .i_global_io_reset(cmd[8]),
	.i_mask_out(cmd[9]), .i_dch_addr_req(areq), .i_dch_in_strobe(hin),
	.i_dch_out_strobe(hout), .i_device_word_req(wreq), .i_burst_request(burst),
	.i_window_closed(win), .i_modulation_allowed(me), .i_modulator_ready(mr),
	.i_device_status(dst), .i_sensitivity_setting(sens), .i_radar_threshold_bits(thr),
	.i_altitude_code(alt), .o_bus_data(dout), .o_bus_data_oe(oe), .o_dch_request(req),
	.o_dch_dir_in(dir), .o_dch_burst(bst), .o_busy(busy), .o_done(done),
	.o_window_done(wdone), .o_irq(irq), .o_select_lines(sel), .o_status_strobe(),
	.o_channel_input_strobe(ist), .o_channel_output_strobe(ost));
dcdi_host_model h(.i_clock(clk), .i_reset_n(rst_n), .i_stall(stall), .i_request(req),
	.i_dir_in(dir), .o_addr_req(areq), .o_in_strobe(hin), .o_out_strobe(hout));
// ----
// Tasks
// ----
task chk(input [15:0] g, input [15:0] e);
begin
	checks = checks + 1;
	if (g !== e)
	begin
		n_fail = n_fail + 1;
		$display("unexpected t=%0t got=%h exp=%h", $time, g, e);
	end
end
endtask
task op(input integer k, input [5:0] c, input [15:0] d);
begin
	@(negedge clk);
	cmd = 10'h001 << k;
	code = c;
	bus = d;
	@(negedge clk);
	cmd = 0;
end
endtask
task rd(input integer k, input [5:0] c, input [15:0] e);
integer i;
begin
	op(k, c, 16'h0000);
	for (i = 0; i < 3 && oe !== 1'b1; i = i + 1) @(negedge clk);
	chk(dout, e);
end
endtask
task t_select;
integer i;
begin
	for (i = 0; i < 6; i = i + 1)
	begin
		op(2, 7, {12'hABC, CS[23-4*i -: 4]});
		@(negedge clk);
		chk({11'h000, sel}, {11'h000, LS[29-5*i -: 5]});
		chk({15'h0000, dir}, {15'h0000, CS[20-4*i]});
		rd(4, 7, {12'h000, CS[23-4*i -: 4]});
	end
	op(2, 6, 16'h0003);
	@(negedge clk);
	chk({11'h000, sel}, 16'h0000);
	me = 1;
	mr = 1;
	dst = 12'h123;
	rd(4, 7, 16'hD234);
	me = 0;
	mr = 0;
	dst = 0;
	rd(3, 6, {2'b01, 3'h4, 1'b1, 10'h2A5});
	sens = 3'h0;
	thr = 3'h7;
	alt = 10'h15A;
	rd(3, 6, {2'b11, 3'h0, 1'b1, 10'h15A});
end
endtask
task t_xfer(input [3:0] s, input [15:0] n, input b);
integer a, i;
begin
	op(2, 7, {12'h000, s});
	op(0, 7, 16'h0100);
	op(1, 7, -n);
	a = n_io;
	stall = 1;
	burst = b;
	op(5, 7, 16'h0000);
	@(negedge clk);
	chk(flg, 16'h0010);
	wreq = 1;
	repeat (4) @(negedge clk);
	chk(flg, 16'h0011);
	chk({15'h0000, bst}, {15'h0000, b});
	stall = 0;
	for (i = 0; i < 200 && done !== 1'b1; i = i + 1) @(negedge clk);
	wreq = 0;
	burst = 0;
	repeat (4) @(negedge clk);
	chk(n_io - a, n);
	chk(flg, 16'h000A);
	rd(3, 7, 16'h0100 + n);
end
endtask
task t_flags;
begin
	op(9, 7, 16'h0080);
	@(negedge clk);
	chk(flg, 16'h0008);
	op(9, 7, 16'hFF7F);
	@(negedge clk);
	chk(flg, 16'h000A);
	win = 1;
	@(negedge clk);
	win = 0;
	@(negedge clk);
	chk(flg, 16'h000E);
	op(7, 7, 16'h0000);
	@(negedge clk);
	chk(flg, 16'h000A);
	op(6, 7, 16'h0000);
	@(negedge clk);
	chk(flg, 16'h0000);
	stall = 1;
	wreq = 1;
	op(5, 7, 16'h0000);
	op(8, 0, 16'h0000);
	chk(flg, 16'h0000);
	wreq = 0;
	stall = 0;
end
endtask
task test_done;
begin
	$display("checks=%0d n_fail=%0d", checks, n_fail);
	if (n_fail == 0 && checks > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
end
endtask
// ----
// Sequence
// ----
initial
begin
	repeat (8) @(negedge clk);
	rst_n = 1;
	t_select;
	t_xfer(4'h5, 16'h0003, 1'b1);
	t_xfer(4'h0, 16'h0002, 1'b0);
	t_flags;
	test_done;
end
initial
begin
	#100000;
	n_fail = n_fail + 1;
	test_done;
end
endmodule // data_channel_dma_interface_tb_top
